// ===== design/gas_log_report_streamer.v
// Report streamer: formats logged gas samples into ASCII lines, paces
// them with XON/XOFF, and runs the graph cursor. AXI4-Lite registers.
// Assumes a serial transmitter with valid/ready and a log with read ack.
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "gas_log_consts.vh"
module gas_log_report_streamer #(
  parameter MS_CYCLES = `MS_CYCLES,
  parameter BLINK_CYCLES = `BLINK_CYCLES
) (
  input wire CLK_I, // System clock
  input wire RESET_I, // Sync reset, high
  input wire [7:0] S_AXI_AWADDR_I, // Write address
  input wire S_AXI_AWVALID_I, // Write address valid
  output reg S_AXI_AWREADY_O, // Write address ready
  input wire [31:0] S_AXI_WDATA_I, // Write data
  input wire [3:0] S_AXI_WSTRB_I, // Byte strobes
  input wire S_AXI_WVALID_I, // Write data valid
  output reg S_AXI_WREADY_O, // Write data ready
  output reg [1:0] S_AXI_BRESP_O, // Write response
  output reg S_AXI_BVALID_O, // Write response valid
  input wire S_AXI_BREADY_I, // Write response ready
  input wire [7:0] S_AXI_ARADDR_I, // Read address
  input wire S_AXI_ARVALID_I, // Read address valid
  output reg S_AXI_ARREADY_O, // Read address ready
  output reg [31:0] S_AXI_RDATA_O, // Read data
  output reg [1:0] S_AXI_RRESP_O, // Read response
  output reg S_AXI_RVALID_O, // Read data valid
  input wire S_AXI_RREADY_I, // Read data ready
  output reg [7:0] TX_DATA_O, // Character to send
  output reg TX_VALID_O, // Character offered
  input wire TX_READY_I, // Transmitter takes character
  input wire TX_BUSY_I, // Transmitter shifting
  input wire [7:0] RX_DATA_I, // Received character
  input wire RX_VALID_I, // Received strobe
  output reg LOG_RD_O, // Log read pulse
  output reg [23:0] LOG_ADDR_O, // Sample number
  input wire LOG_ACK_I, // Log data valid
  input wire [15:0] LOG_DATA_I, // Signed reading
  input wire LOG_LOGGED_I, // Slot holds a sample
  input wire LOG_TROUBLE_I, // Trouble alarm at sample
  input wire LOG_EMPTY_I, // Log holds no record
  input wire [23:0] LOG_NEWEST_I, // Newest sample number
  input wire [5:0] SAMPLE_MIN_I, // Sampling interval, minutes
  input wire PROTO_ASCII_I, // Serial protocol is ASCII
  output reg PRINT_BLINK_O, // Blinking printing lamp
  output reg PRINT_EXC_O // Print refused
);
  localparam P_IDLE = 3'd0;
  localparam P_STAMP = 3'd1;
  localparam P_FETCH = 3'd2;
  localparam P_WAITL = 3'd3;
  localparam P_SEND = 3'd4;
  localparam P_EOL = 3'd5;
  localparam P_DLY = 3'd6;

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  // ASCII digit of m at decimal position p
  function [7:0] dig(input [16:0] m, input [2:0] p);
    reg [16:0] q;
    begin
      case (p)
        3'd0: q = m;
        3'd1: q = m / 17'd10;
        3'd2: q = m / 17'd100;
        3'd3: q = m / 17'd1000;
        default: q = m / 17'd10000;
      endcase
      q = q % 17'd10;
      dig = `CH_ZERO + q[7:0];
    end
  endfunction

  // Samples per day for an interval
  function [10:0] spd(input [5:0] iv);
    begin
      spd = `MIN_PER_DAY / {5'h0, iv};
    end
  endfunction

  function [15:0] clampv(input [15:0] v);
    begin
      if ($signed(v) < $signed(`CLAMP_LO)) clampv = `CLAMP_LO;
      else if ($signed(v) > $signed(`CLAMP_HI)) clampv = `CLAMP_HI;
      else clampv = v;
    end
  endfunction

  // Reading field: length and bytes, TAB first
  function [51:0] fld(input [15:0] v, input lg, input tr);
    reg [47:0] s;
    reg [15:0] ng;
    reg [13:0] m;
    reg [2:0] nd;
    reg [2:0] k;
    integer i;
    begin
      s = {40'h0, `CH_TAB};
      k = 3'd1;
      nd = 3'd4;
      m = 14'h0;
      ng = 16'h0 - v;
      if (!lg) begin
        s[39:8] = {4{`CH_DASH}};
      end else if (tr) begin
        s[39:8] = {4{`CH_F}};
      end else begin
        if (v[15]) begin
          s[15:8] = `CH_DASH;
          k = 3'd2;
          m = ng[13:0];
        end else begin
          m = v[13:0];
        end
        nd = (m >= 14'd1000) ? 3'd4 : (m >= 14'd100) ? 3'd3 :
             (m >= 14'd10) ? 3'd2 : 3'd1;
        for (i = 0; i < 4; i = i + 1) begin
          if (i < nd) s[8*(k+i) +: 8] = dig({3'h0, m}, nd - 3'd1 - i[2:0]);
        end
      end
      fld = {1'b0, k + nd, s};
    end
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  reg aw_got, w_got, go_req, key_up, key_dn, cur_wr;
  reg [7:0] waddr;
  reg [31:0] wdata;
  reg [3:0] wstrb;
  reg crlf, hdx, graph_on, g_prev, chosen, paused, log_pend, log_gr;
  reg g_req_t, g_done_t, rep_done, c_lg, c_tr;
  reg [4:0] width, col;
  reg [13:0] dly_ms, ms_left;
  reg [15:0] first, days, range, day, day_end, c_val;
  reg [23:0] cursor, frozen, sn;
  reg [2:0] pst, pa;
  reg [95:0] fb;
  reg [3:0] flen, fidx;
  reg [10:0] mins;
  reg [6:0] c_pct;
  reg [31:0] ms_cnt, bl_cnt;
  wire printing = (pst != P_IDLE);
  wire [5:0] ival = (SAMPLE_MIN_I == 6'h0) ? 6'h1 : SAMPLE_MIN_I;
  wire [10:0] per_day = spd(ival);
  wire [23:0] c_slot = cursor % {13'h0, per_day};
  wire [23:0] c_dayw = cursor / {13'h0, per_day};
  wire [15:0] c_day = c_dayw[15:0];
  wire [29:0] c_minw = c_slot * {24'h0, ival};
  wire [10:0] c_min = c_minw[10:0];
  // Register read value with hit flag
  function [32:0] reg_word(input [7:0] a);
    begin
      if (a == `A_CTRL) reg_word = {1'b1, 19'h0, width, 5'h0, hdx, crlf, 1'b0};
      else if (a == `A_DELAY) reg_word = {1'b1, 18'h0, dly_ms};
      else if (a == `A_SPAN) reg_word = {1'b1, days, first};
      else if (a == `A_STAT) reg_word = {1'b1, 28'h0, graph_on, PRINT_EXC_O, paused, printing};
      else if (a == `A_GRAPH) reg_word = {1'b1, 31'h0, graph_on};
      else if (a == `A_CURSOR) reg_word = {1'b1, 8'h0, cursor};
      else if (a == `A_CINFO) reg_word = {1'b1, 1'b0, c_pct, 6'h0, c_tr, c_lg, c_val};
      else if (a == `A_CTIME) reg_word = {1'b1, 5'h0, c_min, c_day};
      else if (a == `A_RANGE) reg_word = {1'b1, 16'h0, range};
      else if (a == `A_FROZEN) reg_word = {1'b1, 8'h0, frozen};
      else reg_word = 33'h0;
    end
  endfunction
  wire [32:0] wr_cur = reg_word(waddr);
  wire [31:0] mask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
  wire [31:0] wm = (wr_cur[31:0] & ~mask) | (wdata & mask);
  wire [32:0] rd_cur = reg_word(S_AXI_ARADDR_I);
  wire [11:0] mins_nx = {1'b0, mins} + {6'h0, ival};
  wire wrap = (mins_nx >= {1'b0, `MIN_PER_DAY});
  wire [15:0] fv = clampv(LOG_DATA_I);
  wire [51:0] fr = fld(fv, LOG_LOGGED_I, LOG_TROUBLE_I);
  wire [19:0] pct_w = ({4'h0, fv} * `PCT_SCALE) / {4'h0, range};
  wire [39:0] frst = {13'h0, per_day} * {24'h0, first};

  // ---------------------------------------------------------------
  // AXI4-Lite slave and registers
  // ---------------------------------------------------------------
  // Address and data taken in either order; answer after both
  always @(posedge CLK_I) begin
    if (RESET_I) begin
      S_AXI_AWREADY_O <= 1'b0;
      S_AXI_WREADY_O <= 1'b0;
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= 2'b00;
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RRESP_O <= 2'b00;
      S_AXI_RDATA_O <= 32'h0;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      waddr <= 8'h0;
      wdata <= 32'h0;
      wstrb <= 4'h0;
      go_req <= 1'b0;
      key_up <= 1'b0;
      key_dn <= 1'b0;
      cur_wr <= 1'b0;
      crlf <= 1'b0;
      hdx <= 1'b0;
      width <= `WID_RST;
      dly_ms <= 14'h0;
      first <= 16'h0;
      days <= 16'h1;
      range <= `RANGE_RST;
      graph_on <= 1'b0;
    end else begin
      go_req <= 1'b0;
      key_up <= 1'b0;
      key_dn <= 1'b0;
      cur_wr <= 1'b0;
      S_AXI_AWREADY_O <= S_AXI_AWVALID_I & ~S_AXI_AWREADY_O & ~aw_got & ~S_AXI_BVALID_O;
      S_AXI_WREADY_O <= S_AXI_WVALID_I & ~S_AXI_WREADY_O & ~w_got & ~S_AXI_BVALID_O;
      if (S_AXI_AWVALID_I & S_AXI_AWREADY_O) begin
        aw_got <= 1'b1;
        waddr <= S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I & S_AXI_WREADY_O) begin
        w_got <= 1'b1;
        wdata <= S_AXI_WDATA_I;
        wstrb <= S_AXI_WSTRB_I;
      end
      if (aw_got & w_got) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O <= wr_cur[32] ? 2'b00 : 2'b10;
        if (waddr == `A_CTRL) begin
          crlf <= wm[`F_CRLF];
          hdx <= wm[`F_HDX];
          go_req <= wm[`F_START];
          if (wm[`F_WID +: 5] == 5'h0) width <= 5'd1;
          else if (wm[`F_WID +: 5] > `WID_MAX) width <= `WID_MAX;
          else width <= wm[`F_WID +: 5];
        end else if (waddr == `A_DELAY) begin
          dly_ms <= (wm[13:0] > `DLY_MAX_MS || wm[31:14] != 18'h0) ? `DLY_MAX_MS : wm[13:0];
        end else if (waddr == `A_SPAN) begin
          first <= wm[15:0];
          days <= wm[31:16];
        end else if (waddr == `A_GRAPH) begin
          graph_on <= wm[0];
          key_up <= wm[`F_KEYUP];
          key_dn <= wm[`F_KEYDN];
        end else if (waddr == `A_CURSOR) begin
          cur_wr <= 1'b1;
        end else if (waddr == `A_RANGE) begin
          range <= wm[15:0];
        end
      end else if (S_AXI_BVALID_O & S_AXI_BREADY_I) begin
        S_AXI_BVALID_O <= 1'b0;
      end
      S_AXI_ARREADY_O <= S_AXI_ARVALID_I & ~S_AXI_ARREADY_O & ~S_AXI_RVALID_O;
      if (S_AXI_ARVALID_I & S_AXI_ARREADY_O) begin
        S_AXI_RVALID_O <= 1'b1;
        S_AXI_RDATA_O <= rd_cur[31:0];
        S_AXI_RRESP_O <= rd_cur[32] ? 2'b00 : 2'b10;
      end else if (S_AXI_RVALID_O & S_AXI_RREADY_I) begin
        S_AXI_RVALID_O <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Graph cursor
  // ---------------------------------------------------------------
  // Each cursor change toggles a refresh request to the log port
  always @(posedge CLK_I) begin
    if (RESET_I) begin
      g_prev <= 1'b0;
      cursor <= 24'h0;
      frozen <= 24'h0;
      chosen <= 1'b0;
      g_req_t <= 1'b0;
    end else begin
      g_prev <= graph_on;
      if (cur_wr) begin
        cursor <= wdata[23:0];
        chosen <= 1'b1;
        g_req_t <= ~g_req_t;
      end else if (graph_on & ~g_prev) begin
        frozen <= LOG_NEWEST_I;
        if (!chosen) cursor <= LOG_NEWEST_I;
        g_req_t <= ~g_req_t;
      end else if (graph_on & key_up & (cursor != 24'h0)) begin
        cursor <= cursor - 24'h1;
        chosen <= 1'b1;
        g_req_t <= ~g_req_t;
      end else if (graph_on & key_dn & (cursor < frozen)) begin
        cursor <= cursor + 24'h1;
        chosen <= 1'b1;
        g_req_t <= ~g_req_t;
      end
    end
  end

  // ---------------------------------------------------------------
  // Report engine, log port and flow control
  // ---------------------------------------------------------------
  always @(posedge CLK_I) begin
    if (RESET_I) begin
      pst <= P_IDLE;
      pa <= P_IDLE;
      fb <= 96'h0;
      flen <= 4'h0;
      fidx <= 4'h0;
      day <= 16'h0;
      day_end <= 16'h0;
      mins <= 11'h0;
      sn <= 24'h0;
      col <= 5'h0;
      rep_done <= 1'b0;
      ms_cnt <= 32'h0;
      ms_left <= 14'h0;
      paused <= 1'b0;
      TX_DATA_O <= 8'h0;
      TX_VALID_O <= 1'b0;
      LOG_RD_O <= 1'b0;
      LOG_ADDR_O <= 24'h0;
      log_pend <= 1'b0;
      log_gr <= 1'b0;
      g_done_t <= 1'b0;
      c_val <= 16'h0;
      c_lg <= 1'b0;
      c_tr <= 1'b0;
      c_pct <= 7'h0;
      PRINT_EXC_O <= 1'b0;
    end else begin
      LOG_RD_O <= 1'b0;
      // receive ignored while half duplex line transmits
      if (RX_VALID_I & printing & ~(hdx & TX_BUSY_I)) begin
        if (RX_DATA_I == `CH_XOFF) paused <= 1'b1;
        // XON resumes at the next character
        else if (RX_DATA_I == `CH_XON) paused <= 1'b0;
      end
      case (pst)
        P_IDLE: begin
          if (go_req) begin
            if (LOG_EMPTY_I | ~PROTO_ASCII_I) begin
              PRINT_EXC_O <= 1'b1;
            end else begin
              PRINT_EXC_O <= 1'b0;
              // begin at midnight of start day
              day <= first;
              day_end <= first + days;
              mins <= 11'h0;
              sn <= frst[23:0];
              col <= 5'h0;
              paused <= 1'b0;
              pst <= (days == 16'h0) ? P_IDLE : P_STAMP;
            end
          end
        end
        P_STAMP: begin
          // date then time lead the line
          fb <= {8'h0, dig({6'h0, mins % 11'd60}, 3'd0), dig({6'h0, mins % 11'd60}, 3'd1),
                 `CH_COLON, dig({6'h0, mins / 11'd60}, 3'd0), dig({6'h0, mins / 11'd60}, 3'd1),
                 `CH_TAB, dig({1'b0, day}, 3'd0), dig({1'b0, day}, 3'd1),
                 dig({1'b0, day}, 3'd2), dig({1'b0, day}, 3'd3), dig({1'b0, day}, 3'd4)};
          flen <= 4'd11;
          fidx <= 4'h0;
          pa <= P_FETCH;
          pst <= P_SEND;
        end
        P_SEND: begin
          // offered character completes; pause only between characters
          if (TX_VALID_O) begin
            if (TX_READY_I) TX_VALID_O <= 1'b0;
          end else if (fidx == flen) begin
            pst <= pa;
          end else if (!paused) begin
            TX_DATA_O <= fb[8*fidx +: 8];
            TX_VALID_O <= 1'b1;
            fidx <= fidx + 4'h1;
          end
        end
        P_EOL: begin
          fb <= {80'h0, `CH_LF, `CH_CR};
          flen <= crlf ? 4'd2 : 4'd1;
          fidx <= 4'h0;
          pa <= rep_done ? P_IDLE : ((dly_ms == 14'h0) ? P_STAMP : P_DLY);
          ms_left <= dly_ms;
          ms_cnt <= 32'h0;
          pst <= P_SEND;
        end
        P_DLY: begin
          if (ms_cnt == MS_CYCLES - 1) begin
            ms_cnt <= 32'h0;
            ms_left <= ms_left - 14'h1;
            if (ms_left == 14'h1) pst <= P_STAMP;
          end else begin
            ms_cnt <= ms_cnt + 32'h1;
          end
        end
        default: ;
      endcase
      // Log port: report fetches first, cursor refresh when idle
      if (!log_pend) begin
        if (pst == P_FETCH) begin
          LOG_ADDR_O <= sn;
          LOG_RD_O <= 1'b1;
          log_pend <= 1'b1;
          log_gr <= 1'b0;
          pst <= P_WAITL;
        end else if (pst == P_IDLE && g_req_t != g_done_t) begin
          LOG_ADDR_O <= cursor;
          LOG_RD_O <= 1'b1;
          log_pend <= 1'b1;
          log_gr <= 1'b1;
          g_done_t <= g_req_t;
        end
      end else if (LOG_ACK_I) begin
        log_pend <= 1'b0;
        if (log_gr) begin
          c_val <= fv;
          c_lg <= LOG_LOGGED_I;
          c_tr <= LOG_TROUBLE_I;
          // bar height in percent of range
          if (fv[15] || range == 16'h0) c_pct <= 7'h0;
          else if (pct_w > {13'h0, `PCT_MAX}) c_pct <= `PCT_MAX;
          else c_pct <= pct_w[6:0];
        end else begin
          fb <= {48'h0, fr[47:0]};
          flen <= fr[51:48];
          fidx <= 4'h0;
          // next reading one interval later, across lines
          sn <= sn + 24'h1;
          mins <= wrap ? mins_nx[10:0] - `MIN_PER_DAY : mins_nx[10:0];
          if (wrap) day <= day + 16'h1;
          rep_done <= wrap & (day + 16'h1 == day_end);
          col <= ((col + 5'h1 == width) | (wrap & (day + 16'h1 == day_end))) ? 5'h0 : col + 5'h1;
          pa <= ((col + 5'h1 == width) | (wrap & (day + 16'h1 == day_end))) ? P_EOL : P_FETCH;
          pst <= P_SEND;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Printing lamp
  // ---------------------------------------------------------------
  // blink until last character is sent
  always @(posedge CLK_I) begin
    if (RESET_I) begin
      bl_cnt <= 32'h0;
      PRINT_BLINK_O <= 1'b0;
    end else if (!printing) begin
      bl_cnt <= 32'h0;
      PRINT_BLINK_O <= 1'b0;
    end else if (bl_cnt == BLINK_CYCLES - 1) begin
      bl_cnt <= 32'h0;
      PRINT_BLINK_O <= ~PRINT_BLINK_O;
    end else begin
      bl_cnt <= bl_cnt + 32'h1;
    end
  end
endmodule // gas_log_report_streamer
`default_nettype wire

// ===== design/gas_log_consts.vh
// Constants for the gas log report streamer: register map, fields,
// characters, limits and timing. Assumes a 125 MHz system clock.
`ifndef GAS_LOG_CONSTS_VH
`define GAS_LOG_CONSTS_VH
// Register byte offsets
`define A_CTRL 8'h00
`define A_DELAY 8'h04
`define A_SPAN 8'h08
`define A_STAT 8'h0c
`define A_GRAPH 8'h10
`define A_CURSOR 8'h14
`define A_CINFO 8'h18
`define A_CTIME 8'h1c
`define A_RANGE 8'h20
`define A_FROZEN 8'h24
// Field positions, reset values and limits
`define F_START 0
`define F_CRLF 1
`define F_HDX 2
`define F_WID 8
`define F_KEYUP 1
`define F_KEYDN 2
`define WID_RST 5'd4
`define WID_MAX 5'd30
`define RANGE_RST 16'h0064
`define DLY_MAX_MS 14'd10000
// Characters
`define CH_TAB 8'h09
`define CH_CR 8'h0d
`define CH_LF 8'h0a
`define CH_XOFF 8'h13
`define CH_XON 8'h11
`define CH_DASH 8'h2d
`define CH_F 8'h46
`define CH_COLON 8'h3a
`define CH_ZERO 8'h30
// Reading limits, scale and day length
`define CLAMP_LO 16'hfc19
`define CLAMP_HI 16'h270f
`define PCT_SCALE 20'd100
`define PCT_MAX 7'd127
`define MIN_PER_DAY 11'd1440
// Timing
`define CLK_NS 8
`define MS_NS 1000000
`define MS_CYCLES (`MS_NS / `CLK_NS)
`define BLINK_MS 500
`define BLINK_CYCLES (`BLINK_MS * `MS_CYCLES)
`endif

// ===== sim/gas_log_report_streamer_assertions.sv
// Checker on the report streamer ports.
// Bound to the top module; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module gas_log_chk (
  input wire logic CLK_I, // Clock
  input wire logic RESET_I, // Reset
  input wire logic S_AXI_AWVALID_I, // Aw valid
  input wire logic S_AXI_AWREADY_O, // Aw ready
  input wire logic S_AXI_BVALID_O, // B valid
  input wire logic S_AXI_BREADY_I, // B ready
  input wire logic [7:0] TX_DATA_O, // Char
  input wire logic TX_VALID_O, // Offered
  input wire logic TX_READY_I, // Taken
  input wire logic TX_BUSY_I, // Shifting
  input wire logic [7:0] RX_DATA_I, // Rx char
  input wire logic RX_VALID_I, // Rx strobe
  input wire logic LOG_RD_O, // Log read
  input wire logic PRINT_BLINK_O // Lamp
);
  default clocking @(posedge CLK_I);
  endclocking
  default disable iff (RESET_I);
  // --------------------
  // Serial side
  // --------------------
  a_tx_held: assert property (TX_VALID_O && !TX_READY_I
    |=> TX_VALID_O && $stable(TX_DATA_O)) else $error("offered char changed");
  a_tx_once: assert property (TX_VALID_O && TX_READY_I
    |=> !(TX_VALID_O && TX_READY_I)) else $error("char taken twice");
  // Allow the pipeline three edges before the pause bites
  a_xoff_stop: assert property (RX_VALID_I && RX_DATA_I == 8'h13
    && !TX_BUSY_I && !TX_VALID_O |-> ##3 !$rose(TX_VALID_O) [*4])
    else $error("char offered after pause");
  a_reset_quiet: assert property ($fell(RESET_I) |-> !TX_VALID_O
    && !PRINT_BLINK_O && !LOG_RD_O && !S_AXI_BVALID_O) else $error("busy after reset");
  a_log_pulse: assert property (LOG_RD_O |=> !LOG_RD_O)
    else $error("log read too long");
  // --------------------
  // Register bus
  // --------------------
  a_aw_pulse: assert property (S_AXI_AWREADY_O |=> !S_AXI_AWREADY_O)
    else $error("aw ready too long");
  a_b_bound: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O
    |-> ##[1:4] S_AXI_BVALID_O) else $error("write answer late");
  a_b_once: assert property (S_AXI_BVALID_O && S_AXI_BREADY_I |=> !S_AXI_BVALID_O)
    else $error("write answer repeated");
endmodule // gas_log_chk
bind gas_log_report_streamer gas_log_chk chk (.CLK_I(CLK_I), .RESET_I(RESET_I),
  .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
  .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I),
  .TX_DATA_O(TX_DATA_O), .TX_VALID_O(TX_VALID_O), .TX_READY_I(TX_READY_I),
  .TX_BUSY_I(TX_BUSY_I), .RX_DATA_I(RX_DATA_I), .RX_VALID_I(RX_VALID_I),
  .LOG_RD_O(LOG_RD_O), .PRINT_BLINK_O(PRINT_BLINK_O));
`default_nettype wire

// ===== sim/gas_log_printer.sv
// Serial printer model: slow taker, answers with pause and resume.
// Assumes the streamer's character handshake and receive strobe.
`timescale 1ns/1ps
`default_nettype none
module gas_log_printer (
  input wire logic clk_i, // Clock
  input wire logic [7:0] data_i, // Char in
  input wire logic valid_i, // Char offered
  output logic ready_o = 0, // Char taken
  output logic busy_o = 0, // Shifting
  output logic [7:0] rx_o = 0, // Flow char
  output logic rx_valid_o = 0, // Flow strobe
  input wire logic [31:0] stall_at_i, // Chars before pause, 0 none
  input wire logic [31:0] stall_len_i // Pause cycles
);
  logic [7:0] got[$];
  int sh = 0, pause = 0, late = 0;
  // Idle receive line toggles so stale codes never look valid
  always @(posedge clk_i) begin
    ready_o <= valid_i && !ready_o && sh == 0;
    busy_o <= sh != 0;
    rx_valid_o <= 0;
    rx_o <= ~rx_o;
    if (sh > 0) sh <= sh - 1;
    if (pause > 1) pause <= pause - 1;
    if (valid_i && ready_o) begin
      got.push_back(data_i);
      sh <= 3;
      if (pause > 0) late <= late + 1;
      if (got.size() == stall_at_i) begin
        rx_o <= 8'h13;
        rx_valid_o <= 1;
        pause <= stall_len_i;
      end
    end
    if (pause == 1) begin
      rx_o <= 8'h11;
      rx_valid_o <= 1;
      pause <= 0;
    end
  end
endmodule // gas_log_printer
`default_nettype wire

// ===== sim/gas_log_report_streamer_tb_top.sv
// Bench: report text, pacing, flow control, refusal and graph cursor.
// Assumes the streamer, its bound checker and the printer model.
`timescale 1ns/1ps
`default_nettype none
module gas_log_report_streamer_tb_top;
  logic clk = 0, rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, ack = 0;
  logic lgd = 0, trb = 0, emp = 0, asc = 1, seen = 0, awr, wrr, bv, arr, rv;
  logic txv, txr, bsy, rxv, lrd, blk, exc;
  logic [7:0] awa = 0, ara = 0, txd, rxd, prev = 0;
  logic [31:0] wd = 0, rdat, stall = 0, d;
  logic [23:0] ladr, newest = 10;
  logic [5:0] smin = 6'd60;
  logic [15:0] ldat = 0;
  logic [1:0] br, rr, r;
  int errors = 0, n_checks = 0, cyc = 0, pt = 0, dly = 0, crlf = 0, i;
  logic [15:0] vals[6] = '{16'h5555, 16'h0005, 16'hf830, 16'h2ee0, 16'h002a, 16'hfff9};
  string txt[6] = '{"----", "FFFF", "-999", "9999", "42", "-7"};
  // Width, eol (+2 half duplex), delay ms, first day, days, pause after char, interval
  int rows[6][7] = '{'{4, 0, 0, 0, 1, 0, 60}, '{30, 1, 2, 1, 1, 0, 30},
    '{1, 1, 0, 0, 1, 0, 60}, '{31, 0, 1, 0, 1, 0, 60}, '{0, 1, 0, 2, 2, 0, 60},
    '{7, 3, 0, 0, 1, 9, 60}};
  gas_log_report_streamer #(.MS_CYCLES(4), .BLINK_CYCLES(8)) dut (.CLK_I(clk),
    .RESET_I(rst), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
    .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrr),
    .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bre), .S_AXI_ARADDR_I(ara),
    .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdat),
    .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rre), .TX_DATA_O(txd),
    .TX_VALID_O(txv), .TX_READY_I(txr), .TX_BUSY_I(bsy), .RX_DATA_I(rxd),
    .RX_VALID_I(rxv), .LOG_RD_O(lrd), .LOG_ADDR_O(ladr), .LOG_ACK_I(ack),
    .LOG_DATA_I(ldat), .LOG_LOGGED_I(lgd), .LOG_TROUBLE_I(trb), .LOG_EMPTY_I(emp),
    .LOG_NEWEST_I(newest), .SAMPLE_MIN_I(smin), .PROTO_ASCII_I(asc),
    .PRINT_BLINK_O(blk), .PRINT_EXC_O(exc));
  gas_log_printer p (.clk_i(clk), .data_i(txd), .valid_i(txv), .ready_o(txr),
    .busy_o(bsy), .rx_o(rxd), .rx_valid_o(rxv), .stall_at_i(stall), .stall_len_i(200));
  initial begin
    forever #4 clk = ~clk;
  end
  // Log memory: six kinds of slot, garbage outside the answer
  always @(posedge clk) begin
    ack <= lrd;
    ldat <= ~ldat;
    lgd <= ~lgd;
    trb <= ~trb;
    if (lrd) begin
      ldat <= vals[ladr % 6];
      lgd <= ladr % 6 != 0;
      trb <= ladr % 6 == 1;
    end
  end
  // Lamp watch and spacing after each line end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (blk === 1'b1) seen <= 1;
    if (txv && txr) begin
      if (prev === (crlf ? 8'h0a : 8'h0d)) chk("gap", cyc - pt >= dly * 4, 1);
      prev <= txd;
      pt <= cyc;
    end
  end
  task automatic chk(input string what, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    awa <= a;
    wd <= v;
    awv <= 1;
    wv <= 1;
    bre <= 1;
    do begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wrr) wv <= 0;
    end while (bv !== 1'b1);
    chk("bresp", br, 0);
    bre <= 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] s);
    @(posedge clk);
    ara <= a;
    arv <= 1;
    rre <= 1;
    do begin
      @(posedge clk);
      if (arr) arv <= 0;
    end while (rv !== 1'b1);
    v = rdat;
    s = rr;
    rre <= 0;
  endtask
  task automatic rc(input string w, input logic [7:0] a, input logic [31:0] e);
    rd(a, d, r);
    chk(w, d, e);
    chk(w, r, 0);
  endtask
  task automatic run(input int w, cr, dl, first, days, st, iv);
    int n, k, wid, pd;
    string s;
    wid = w < 1 ? 1 : (w > 30 ? 30 : w);
    pd = 1440 / iv;
    s = "";
    for (n = first * pd; n < (first + days) * pd; n++) begin
      k = n - first * pd;
      if (k % wid == 0)
        s = {s, $sformatf("%05d\t%02d:%02d", n / pd, n % pd * iv / 60, n % pd * iv % 60)};
      s = {s, "\t", txt[n % 6]};
      if (k % wid == wid - 1 || n == (first + days) * pd - 1) s = {s, cr ? "\r\n" : "\r"};
    end
    stall <= st;
    smin <= iv;
    crlf = cr;
    dly = dl;
    seen = 0;
    p.got.delete();
    wr(8'h04, dl);
    wr(8'h08, (days << 16) | first);
    wr(8'h00, (w << 8) | (cr << 1) | 1);
    do begin
      rd(8'h0c, d, r);
    end while (d[0] !== 1'b0);
    chk("blink", seen, 1);
    chk("lamp", blk, 0);
    chk("exc", exc, 0);
    chk("held", p.late > 1, 0);
    chk("len", p.got.size(), s.len());
    for (n = 0; n < s.len() && n < p.got.size(); n++) chk("char", p.got[n], s[n]);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // A hang costs one mismatch and ends the run
  initial begin
    #800000;
    errors++;
    test_done();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 0;
    rc("ctrl", 8'h00, 32'h400);
    rc("range", 8'h20, 32'h64);
    rc("span", 8'h08, 32'h10000);
    rd(8'h30, d, r);
    chk("hole", r, 2'b10);
    emp <= 1;
    wr(8'h00, 32'h401);
    rc("stat", 8'h0c, 32'h4);
    chk("exc e", exc, 1);
    emp <= 0;
    for (i = 0; i < 6; i++) run(rows[i][0], rows[i][1], rows[i][2], rows[i][3], rows[i][4],
      rows[i][5], rows[i][6]);
    asc <= 0;
    wr(8'h00, 32'h401);
    rc("stat a", 8'h0c, 32'h4);
    chk("exc a", exc, 1);
    wr(8'h20, 32'd200);
    wr(8'h10, 32'h1);
    newest <= 24'd20;
    repeat (40) @(posedge clk);
    rc("frozen", 8'h24, 32'd10);
    rc("cursor", 8'h14, 32'd10);
    rc("info", 8'h18, 32'h1501002a);
    wr(8'h10, 32'h3);
    repeat (40) @(posedge clk);
    rc("left", 8'h14, 32'd9);
    rc("info l", 8'h18, 32'h7f01270f);
    rc("time", 8'h1c, 32'h021c0000);
    wr(8'h10, 32'h5);
    rc("right", 8'h14, 32'd10);
    wr(8'h10, 32'h5);
    rc("stop", 8'h14, 32'd10);
    wr(8'h14, 32'd7);
    wr(8'h10, 32'h0);
    wr(8'h10, 32'h1);
    rc("chosen", 8'h14, 32'd7);
    test_done();
  end
endmodule // gas_log_report_streamer_tb_top
`default_nettype wire
